//--- pkg/pdcs_map.svh
`ifndef PDCS_MAP_SVH
`define PDCS_MAP_SVH
// Overview of operation
// [R1] 256 entry 24-bit palette, block loads; code loads one entry per write
// [R2] Entry zero always outputs black
// [R3] Pixel index ANDed with 8-bit mask
// [R4] Pixel mask reads back unchanged
// [R5] Palette entry components read back by index
// [R6] Load word: index, red, green, blue
// [R7] Defaults: pass-through video, 24 MHz clock
// [R8] Normal video keeps clock selection
// [R9] Lookup mode drives colour from palette
// [R10] Codes 2,3,4 select direct 8/12/16-bit
// [R11] Direct 8-bit mode exists in hardware
// [R12] Host pixel stream synchronous to chosen oscillator; code clocks it on MCLK
// [R13] Route one of eight sockets; 8 reads
// [R14] Sockets 0,7 24M; 1,2,3 others; 4-6 empty
// [R15] Unoccupied socket request leaves clock unchanged
// [R16] Socket mask bits 0-3,7 forced set
// [R17] Oscillator change without runt pulses

// ---------------------------------------------
// Register byte offsets
// ---------------------------------------------
`define PDCS_OFS_CTRL 8'h00
`define PDCS_OFS_MASK 8'h04
`define PDCS_OFS_PAL_WR 8'h08
`define PDCS_OFS_PAL_IDX 8'h0c
`define PDCS_OFS_PAL_RD 8'h10
`define PDCS_OFS_CMD 8'h14
`define PDCS_OFS_CLK_SEL 8'h18
`define PDCS_OFS_SOCKETS 8'h1c

// ---------------------------------------------
// Fields and reset values
// ---------------------------------------------
`define PDCS_CMD_DEFAULT 0
`define PDCS_CMD_NORMAL 1
`define PDCS_CLK_READ_REQ 4'h8
`define PDCS_SOCK_FORCED 8'h8f
`define PDCS_MASK_RST 8'hff
`define PDCS_SEL_DEFAULT 3'h0
`define PDCS_RESP_OKAY 2'h0
`define PDCS_RESP_SLVERR 2'h2

// ---------------------------------------------
// Timing
// ---------------------------------------------
`define PDCS_CLK_NS 8
`define PDCS_SETTLE_NS 100
`define PDCS_SETTLE_CYC \
  ((`PDCS_SETTLE_NS + `PDCS_CLK_NS - 1) / `PDCS_CLK_NS)
`endif

//--- pkg/pdcs_pkg.sv
package pdcs_pkg;
  // Output modes, in control code order
  typedef enum logic [2:0] {
    MODE_PASS, MODE_LUT, MODE_DAC8, MODE_DAC12, MODE_DAC16
  } pdcs_mode_e;
  typedef enum logic [1:0] {CK_RUN, CK_OFF, CK_SWAP} pdcs_ck_e;
  typedef struct packed {
    logic [7:0] blue;
    logic [7:0] green;
    logic [7:0] red;
  } pdcs_rgb_s;
  typedef struct packed {
    pdcs_rgb_s host_rgb;
    logic [15:0] pix;
  } pdcs_pix_s;
endpackage

//--- src/pdcs_top.sv
`timescale 1ns/10ps
`include "pdcs_map.svh"
module pdcs_top #(
  parameter int SETTLE_CYC = `PDCS_SETTLE_CYC,
  parameter int ENTRIES = 256
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  input wire logic PIX_VALID,
  output logic PIX_READY,
  input wire pdcs_pkg::pdcs_pix_s PIX_IN,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output pdcs_pkg::pdcs_rgb_s RGB_OUT,
  output logic [2:0] OSC_SEL,
  output logic OSC_EN
);

  // ---------------------------------------------
  // Elaboration checks
  // ---------------------------------------------
  if (ENTRIES != 256) begin : g_bad_entries
    $error("Palette must have 256 entries");
  end
  if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_settle
    $error("Settle count must be 1 to 255");
  end

  localparam logic [7:0] SETTLE = 8'(SETTLE_CYC);
  localparam logic [7:0] FORCED = `PDCS_SOCK_FORCED;

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  pdcs_pkg::pdcs_rgb_s pal_mem [0:ENTRIES-1];
  pdcs_pkg::pdcs_mode_e mode_reg, mode_next;
  pdcs_pkg::pdcs_ck_e ck_reg, ck_next;
  logic [7:0] mask_reg, mask_next;
  logic [7:0] ridx_reg, ridx_next;
  logic [7:0] sock_reg, sock_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [2:0] sel_reg, sel_next;
  logic [2:0] tgt_reg, tgt_next;
  logic en_reg, en_next;
  logic awh_reg, awh_next;
  logic [7:0] awa_reg, awa_next;
  logic wh_reg, wh_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0] ws_reg, ws_next;
  logic awr_reg, awr_next;
  logic wr_reg, wr_next;
  logic bv_reg, bv_next;
  logic [1:0] br_reg, br_next;
  logic arr_reg, arr_next;
  logic rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0] rr_reg, rr_next;
  logic [1:0] cnt_q_reg, cnt_q_next;
  pdcs_pkg::pdcs_rgb_s head_reg, head_next;
  pdcs_pkg::pdcs_rgb_s tail_reg, tail_next;
  logic prdy_reg, prdy_next;
  logic ov_reg, ov_next;
  logic pal_we;
  logic [7:0] pal_widx;
  pdcs_pkg::pdcs_rgb_s pal_wd;
  logic [7:0] sock_forced;
  logic [7:0] lidx;
  pdcs_pkg::pdcs_rgb_s lut_rgb, rb_rgb, pix_rgb;

  // ---------------------------------------------
  // Socket mask: forced bits cannot clear
  // ---------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_sock
    // [R16] forced occupied bits
    assign sock_forced[i] = FORCED[i];
  end

  // ---------------------------------------------
  // Pixel colour path
  // ---------------------------------------------
  // [R3] index masking
  assign lidx = PIX_IN.pix[7:0] & mask_reg;
  // [R2] entry zero black
  assign lut_rgb = (lidx == 8'h00) ? '0 : pal_mem[lidx];
  assign rb_rgb = (ridx_reg == 8'h00) ? '0 : pal_mem[ridx_reg];

  // Mode select; direct modes expand to 8 bits per gun
  always_comb begin
    unique case (mode_reg)
      pdcs_pkg::MODE_PASS: pix_rgb = PIX_IN.host_rgb;
      // [R9] lookup drives output
      pdcs_pkg::MODE_LUT: pix_rgb = lut_rgb;
      // [R11] direct 8-bit 3-3-2
      pdcs_pkg::MODE_DAC8: pix_rgb = {PIX_IN.pix[7:6], 6'h00,
        PIX_IN.pix[5:3], 5'h00, PIX_IN.pix[2:0], 5'h00};
      // [R10] direct 12-bit 4-4-4
      pdcs_pkg::MODE_DAC12: pix_rgb = {PIX_IN.pix[11:8], 4'h0,
        PIX_IN.pix[7:4], 4'h0, PIX_IN.pix[3:0], 4'h0};
      pdcs_pkg::MODE_DAC16: pix_rgb = {PIX_IN.pix[15:11], 3'h0,
        PIX_IN.pix[10:5], 2'h0, PIX_IN.pix[4:0], 3'h0};
      // Unused codes fall back to host video
      default: pix_rgb = PIX_IN.host_rgb;
    endcase
  end

  // Two-entry buffer; head drives the output pins directly
  always_comb begin
    logic push;
    logic pop;
    push = PIX_VALID & prdy_reg;
    pop = (cnt_q_reg != 2'h0) & OUT_READY;
    head_next = head_reg;
    tail_next = tail_reg;
    cnt_q_next = cnt_q_reg;
    if (pop) begin
      head_next = tail_reg;
    end
    if (push) begin
      if (cnt_q_reg == 2'h0 || (pop && cnt_q_reg == 2'h1)) begin
        head_next = pix_rgb;
      end else begin
        tail_next = pix_rgb;
      end
    end
    if (push && !pop) begin
      cnt_q_next = cnt_q_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_q_next = cnt_q_reg - 2'h1;
    end
    // Ready reflects room after this edge, so no word is lost
    prdy_next = cnt_q_next != 2'h2;
    ov_next = cnt_q_next != 2'h0;
  end

  // ---------------------------------------------
  // Register bus and control
  // ---------------------------------------------
  always_comb begin
    logic do_wr;
    logic [7:0] idx;
    do_wr = awh_reg & wh_reg & !bv_reg;
    awh_next = awh_reg | (AWVALID & awr_reg);
    awa_next = (AWVALID & awr_reg) ? AWADDR : awa_reg;
    wh_next = wh_reg | (WVALID & wr_reg);
    wd_next = (WVALID & wr_reg) ? WDATA : wd_reg;
    ws_next = (WVALID & wr_reg) ? WSTRB : ws_reg;
    bv_next = bv_reg & !BREADY;
    br_next = br_reg;
    mode_next = mode_reg;
    mask_next = mask_reg;
    ridx_next = ridx_reg;
    sock_next = sock_reg;
    tgt_next = tgt_reg;
    pal_we = 1'b0;
    idx = wd_reg[7:0];
    pal_widx = idx;
    pal_wd = wd_reg[31:8];
    if (do_wr) begin
      awh_next = 1'b0;
      wh_next = 1'b0;
      bv_next = 1'b1;
      br_next = `PDCS_RESP_OKAY;
      // Partial strobes are acknowledged but change nothing
      if (ws_reg == 4'hf) begin
        unique case (awa_reg)
          `PDCS_OFS_CTRL: begin
            if (wd_reg[2:0] <= 3'h4) begin
              mode_next = pdcs_pkg::pdcs_mode_e'(wd_reg[2:0]);
            end
          end
          `PDCS_OFS_MASK: mask_next = idx;
          // [R6] packed load word
          // [R1] one entry per write
          `PDCS_OFS_PAL_WR: pal_we = 1'b1;
          `PDCS_OFS_PAL_IDX: ridx_next = idx;
          `PDCS_OFS_PAL_RD: br_next = `PDCS_RESP_OKAY;
          `PDCS_OFS_CMD: begin
            // [R7] restore defaults
            if (wd_reg[`PDCS_CMD_DEFAULT]) begin
              mode_next = pdcs_pkg::MODE_PASS;
              tgt_next = `PDCS_SEL_DEFAULT;
            // [R8] normal video only
            end else if (wd_reg[`PDCS_CMD_NORMAL]) begin
              mode_next = pdcs_pkg::MODE_PASS;
            end
          end
          `PDCS_OFS_CLK_SEL: begin
            // [R15] unoccupied socket ignored
            if (wd_reg[3] == 1'b0 && sock_reg[wd_reg[2:0]]) begin
              tgt_next = wd_reg[2:0];
            end
          end
          `PDCS_OFS_SOCKETS: sock_next = idx | `PDCS_SOCK_FORCED;
          default: br_next = `PDCS_RESP_SLVERR;
        endcase
      end else if (awa_reg[7:5] != 3'h0 || awa_reg[1:0] != 2'h0) begin
        br_next = `PDCS_RESP_SLVERR;
      end
    end
    awr_next = !awh_next & !bv_next;
    wr_next = !wh_next & !bv_next;
    // Read side: one outstanding read, data one cycle after address
    rv_next = rv_reg & !RREADY;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (ARVALID && arr_reg) begin
      rv_next = 1'b1;
      rr_next = `PDCS_RESP_OKAY;
      unique case (ARADDR)
        `PDCS_OFS_CTRL: rd_next = {29'h0, mode_reg};
        // [R4] mask readback
        `PDCS_OFS_MASK: rd_next = {24'h0, mask_reg};
        `PDCS_OFS_PAL_WR: rd_next = 32'h0;
        `PDCS_OFS_PAL_IDX: rd_next = {24'h0, ridx_reg};
        // [R5] entry components readback
        `PDCS_OFS_PAL_RD: rd_next = {rb_rgb, ridx_reg};
        `PDCS_OFS_CMD: rd_next = 32'h0;
        // [R13] current selection readback
        `PDCS_OFS_CLK_SEL: rd_next = {28'h0, !en_reg, sel_reg};
        `PDCS_OFS_SOCKETS: rd_next = {24'h0, sock_reg};
        default: begin
          rd_next = 32'h0;
          rr_next = `PDCS_RESP_SLVERR;
        end
      endcase
    end
    arr_next = !rv_next;
  end

  // ---------------------------------------------
  // Oscillator switch sequencer
  // ---------------------------------------------
  // Break-before-make: enable drops, select moves while the
  // mux output is held low, then enable returns
  always_comb begin
    ck_next = ck_reg;
    cnt_next = cnt_reg;
    sel_next = sel_reg;
    en_next = en_reg;
    unique case (ck_reg)
      pdcs_pkg::CK_RUN: begin
        // [R13] route chosen socket
        if (tgt_reg != sel_reg) begin
          en_next = 1'b0;
          cnt_next = SETTLE;
          ck_next = pdcs_pkg::CK_OFF;
        end
      end
      pdcs_pkg::CK_OFF: begin
        // [R17] hold low before swap
        if (cnt_reg == 8'h01) begin
          sel_next = tgt_reg;
          cnt_next = SETTLE;
          ck_next = pdcs_pkg::CK_SWAP;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      pdcs_pkg::CK_SWAP: begin
        if (cnt_reg == 8'h01) begin
          en_next = 1'b1;
          ck_next = pdcs_pkg::CK_RUN;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
    endcase
  end

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  // Palette holds data only, so it takes no reset
  always_ff @(posedge MCLK) begin
    // [R2] index zero never written
    if (pal_we && pal_widx != 8'h00) begin
      pal_mem[pal_widx] <= pal_wd;
    end
  end

  // Control state
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_reg <= pdcs_pkg::MODE_PASS;
      mask_reg <= `PDCS_MASK_RST;
      ridx_reg <= 8'h00;
      sock_reg <= `PDCS_SOCK_FORCED;
      ck_reg <= pdcs_pkg::CK_RUN;
      cnt_reg <= 8'h00;
      // [R14] socket 0 is 24 MHz
      sel_reg <= `PDCS_SEL_DEFAULT;
      tgt_reg <= `PDCS_SEL_DEFAULT;
      en_reg <= 1'b1;
      awh_reg <= 1'b0;
      awa_reg <= 8'h00;
      wh_reg <= 1'b0;
      wd_reg <= 32'h0;
      ws_reg <= 4'h0;
      awr_reg <= 1'b1;
      wr_reg <= 1'b1;
      bv_reg <= 1'b0;
      br_reg <= 2'h0;
      arr_reg <= 1'b1;
      rv_reg <= 1'b0;
      rd_reg <= 32'h0;
      rr_reg <= 2'h0;
      cnt_q_reg <= 2'h0;
      head_reg <= '0;
      tail_reg <= '0;
      prdy_reg <= 1'b1;
      ov_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      mask_reg <= mask_next;
      ridx_reg <= ridx_next;
      sock_reg <= sock_next | sock_forced;
      ck_reg <= ck_next;
      cnt_reg <= cnt_next;
      sel_reg <= sel_next;
      tgt_reg <= tgt_next;
      en_reg <= en_next;
      awh_reg <= awh_next;
      awa_reg <= awa_next;
      wh_reg <= wh_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      awr_reg <= awr_next;
      wr_reg <= wr_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      arr_reg <= arr_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
      cnt_q_reg <= cnt_q_next;
      head_reg <= head_next;
      tail_reg <= tail_next;
      prdy_reg <= prdy_next;
      ov_reg <= ov_next;
    end
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  assign AWREADY = awr_reg;
  assign WREADY = wr_reg;
  assign BVALID = bv_reg;
  assign BRESP = br_reg;
  assign ARREADY = arr_reg;
  assign RVALID = rv_reg;
  assign RDATA = rd_reg;
  assign RRESP = rr_reg;
  assign PIX_READY = prdy_reg;
  assign OUT_VALID = ov_reg;
  assign RGB_OUT = head_reg;
  assign OSC_SEL = sel_reg;
  assign OSC_EN = en_reg;
endmodule

//--- verif/pdcs_checker_asserts.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module pdcs_checker #(
  parameter int SETTLE_CYC = 13
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [7:0] ARADDR,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic PIX_VALID,
  input wire logic PIX_READY,
  input wire logic OUT_VALID,
  input wire logic OUT_READY,
  input wire pdcs_pkg::pdcs_rgb_s RGB_OUT,
  input wire logic [2:0] OSC_SEL,
  input wire logic OSC_EN
);
  // Off time of a clock change is two settle spans, plus slack
  localparam int SW_MAX = 2 * SETTLE_CYC + 2;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // Clock select and enable
  property p_sel_frozen;
    OSC_EN && $past(OSC_EN) |-> $stable(OSC_SEL);
  endproperty
  a_sel_frozen: assert property (p_sel_frozen)
    else $error("clock select moved while enabled");
  property p_osc_back;
    $fell(OSC_EN) |-> ##[1:SW_MAX] OSC_EN;
  endproperty
  a_osc_back: assert property (p_osc_back)
    else $error("clock stayed off too long");
  // Register bus answers
  property p_rd_ans;
    ARVALID && ARREADY |=> RVALID;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer late");
  property p_rd_hold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data dropped");
  property p_wr_hold;
    BVALID && !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write response dropped");
  property p_unmapped;
    ARVALID && ARREADY && ARADDR[7:5] != 3'h0 |=> RRESP == 2'h2;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  // Pixel path
  property p_out_hold;
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(RGB_OUT);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("colour lost under stall");
  property p_pix_ans;
    PIX_VALID && PIX_READY && !OUT_VALID |=> OUT_VALID;
  endproperty
  a_pix_ans: assert property (p_pix_ans)
    else $error("colour not produced");
  property p_full;
    !PIX_READY |-> OUT_VALID;
  endproperty
  a_full: assert property (p_full)
    else $error("refused while empty");
endmodule

bind pdcs_top pdcs_checker #(.SETTLE_CYC(SETTLE_CYC)) pdcs_checker_inst (
  .MCLK(MCLK), .RSTN(RSTN), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
  .RRESP(RRESP), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
  .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .OUT_VALID(OUT_VALID),
  .OUT_READY(OUT_READY), .RGB_OUT(RGB_OUT), .OSC_SEL(OSC_SEL),
  .OSC_EN(OSC_EN));

//--- verif/pdcs_pix_agent.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host pixel source and colour sink
// ----------------------------------------
module pdcs_pix_agent (
  input wire logic MCLK,
  output logic PIX_VALID,
  input wire logic PIX_READY,
  output pdcs_pkg::pdcs_pix_s PIX_IN,
  input wire logic OUT_VALID,
  output logic OUT_READY,
  input wire pdcs_pkg::pdcs_rgb_s RGB_OUT
);
  pdcs_pkg::pdcs_pix_s txq[$];
  pdcs_pkg::pdcs_rgb_s rxq[$];
  logic stall = 1'b0;
  logic slow = 1'b0;
  // Idle at time zero
  initial begin
    PIX_VALID = 1'b0;
    PIX_IN = '0;
    OUT_READY = 1'b0;
  end
  // pixels on MCLK
  // Sink takes every other cycle; idle data toggles so nothing stale
  always @(posedge MCLK) begin
    if (PIX_VALID && PIX_READY) void'(txq.pop_front());
    if (OUT_VALID && OUT_READY) rxq.push_back(RGB_OUT);
    slow <= ~slow;
    PIX_VALID <= txq.size() != 0;
    PIX_IN <= txq.size() != 0 ? txq[0] : ~PIX_IN;
    OUT_READY <= !stall && slow;
  end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic MCLK = 1'b0;
  logic RSTN = 1'b0;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, OSC_EN;
  logic PIX_VALID, PIX_READY, OUT_VALID, OUT_READY;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, wr_resp;
  logic [2:0] OSC_SEL;
  logic [31:0] scratch;
  pdcs_pkg::pdcs_pix_s PIX_IN;
  pdcs_pkg::pdcs_rgb_s RGB_OUT;
  int bad_count = 0;
  int total_checks = 0;
  // Clock
  always #4 MCLK = ~MCLK;
  // Short settle keeps clock changes quick
  pdcs_top #(.SETTLE_CYC(2)) pdcs_top_inst (.MCLK(MCLK), .RSTN(RSTN),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .PIX_IN(PIX_IN),
    .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .RGB_OUT(RGB_OUT),
    .OSC_SEL(OSC_SEL), .OSC_EN(OSC_EN));
  pdcs_pix_agent pdcs_pix_agent_inst (.MCLK(MCLK),
    .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .PIX_IN(PIX_IN),
    .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .RGB_OUT(RGB_OUT));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge MCLK);
    n = 0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID && n < 500);
    if (!BVALID) bad_count++;
    wr_resp = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge MCLK);
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID && n < 500);
    if (!RVALID) bad_count++;
    d = RDATA;
    RREADY <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic take(input logic [23:0] e);
    int n;
    n = 0;
    while (pdcs_pix_agent_inst.rxq.size() == 0 && n < 200) begin
      @(posedge MCLK);
      n++;
    end
    if (pdcs_pix_agent_inst.rxq.size() == 0)
      bad_count++;
    else
      chk({8'h0, pdcs_pix_agent_inst.rxq.pop_front()}, {8'h0, e});
  endtask
  task automatic px(input logic [15:0] p, input logic [23:0] h,
                    input logic [23:0] e);
    pdcs_pix_agent_inst.txq.push_back({h, p});
    take(e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rchk(8'h04, 32'hff);
    rchk(8'h1c, 32'h8f);
    rchk(8'h18, 32'h0);
    chk({28'h0, OSC_EN, OSC_SEL}, 32'h8);
  endtask
  task automatic t_palette;
    logic [31:0] w [3] = '{32'h33221101, 32'hccbbaaff, 32'h77665500};
    // Back to back loads, index zero among them
    for (int i = 0; i < 3; i++) wr(8'h08, w[i]);
    for (int i = 0; i < 3; i++) begin
      wr(8'h0c, {24'h0, w[i][7:0]});
      rchk(8'h10, w[i][7:0] == 8'h0 ? 32'h0 : w[i]);
    end
  endtask
  task automatic t_lookup;
    wr(8'h08, 32'h56341214);
    wr(8'h04, 32'h7e);
    rchk(8'h04, 32'h7e);
    wr(8'h00, 32'h1);
    px(16'h0095, 24'h5a5a5a, 24'h563412);
    px(16'h0081, 24'h5a5a5a, 24'h0);
    wr(8'h04, 32'hff);
    px(16'h00ff, 24'h5a5a5a, 24'hccbbaa);
  endtask
  task automatic t_direct;
    logic [15:0] pv [3] = '{16'h00b5, 16'h0a5c, 16'h8421};
    logic [23:0] ev [3] = '{24'h80c0a0, 24'ha050c0, 24'h808408};
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 32'(i + 2));
      px(pv[i], 24'h5a5a5a, ev[i]);
    end
  endtask
  task automatic t_buffer;
    wr(8'h00, 32'h0);
    pdcs_pix_agent_inst.stall = 1'b1;
    for (int i = 1; i < 5; i++)
      pdcs_pix_agent_inst.txq.push_back({24'(i), 16'hffff});
    repeat (10) @(posedge MCLK);
    chk({31'h0, PIX_READY}, 32'h0);
    pdcs_pix_agent_inst.stall = 1'b0;
    for (int i = 1; i < 5; i++) take(24'(i));
  endtask
  task automatic t_clock;
    wr(8'h18, 32'h4);
    repeat (8) @(posedge MCLK);
    chk({29'h0, OSC_SEL}, 32'h0);
    wr(8'h1c, 32'h0);
    rchk(8'h1c, 32'h8f);
    wr(8'h1c, 32'h10);
    wr(8'h18, 32'h4);
    repeat (8) @(posedge MCLK);
    chk({28'h0, OSC_EN, OSC_SEL}, 32'hc);
    wr(8'h18, 32'h8);
    rchk(8'h18, 32'h4);
    wr(8'h00, 32'h1);
    wr(8'h14, 32'h2);
    px(16'h00ff, 24'h123456, 24'h123456);
    rchk(8'h18, 32'h4);
    wr(8'h00, 32'h1);
    wr(8'h14, 32'h1);
    repeat (8) @(posedge MCLK);
    rchk(8'h18, 32'h0);
    px(16'h00ff, 24'h654321, 24'h654321);
    rd(8'h20, scratch);
    chk({30'h0, RRESP}, 32'h2);
    wr(8'h20, 32'h0);
    chk({30'h0, wr_resp}, 32'h2);
    wr(8'h04, 32'h3c);
    chk({30'h0, wr_resp}, 32'h0);
  endtask
  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
    {AWADDR, ARADDR, WDATA} = '0;
    WSTRB = 4'hf;
    repeat (4) @(posedge MCLK);
    RSTN <= 1'b1;
    t_reset;
    $display("reset test done");
    t_palette;
    $display("palette test done");
    t_lookup;
    $display("lookup test done");
    t_direct;
    $display("direct test done");
    t_buffer;
    $display("buffer test done");
    t_clock;
    $display("clock test done");
    wrap_up;
  end
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge MCLK);
    bad_count++;
    wrap_up;
  end
endmodule
